// ---- hdl/bfs_pkg.sv ----
// ****************************************************************
// Shared constants and types
// ****************************************************************
package bfs_pkg;

  localparam int CLK_NS = 25;

  // Break-before-make dead interval
  localparam int DEAD_NS = 50;
  localparam logic [9:0] DEAD_CYC = 10'((DEAD_NS + CLK_NS - 1) / CLK_NS);
  // Blanking before the valley current is trusted
  localparam int BLANK_NS = 100;
  localparam logic [9:0] BLANK_CYC = 10'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  // Minimum low-side on time
  localparam int MINOFF_NS = 250;
  localparam logic [9:0] MINOFF_CYC = 10'((MINOFF_NS + CLK_NS - 1) / CLK_NS);

  // Ultrasonic floor on the switching rate
  localparam int US_MIN_KHZ = 20;
  localparam logic [10:0] US_MAX_CYC = 11'((1000000 / US_MIN_KHZ) / CLK_NS);
  localparam logic [10:0] US_FIRE_CYC = US_MAX_CYC - 11'(DEAD_CYC) - 11'h001;

  // Retry delay and soft-start length
  localparam int RETRY_MS = 20;
  localparam int RETRY_CYC_DEF = RETRY_MS * 1000000 / CLK_NS;
  localparam int SS_US = 1000;
  localparam int SS_CYC_DEF = SS_US * 1000 / CLK_NS;
  localparam int LONG_W = 20;

  // Consecutive limited cycles before the overcurrent fault
  localparam logic [7:0] OC_COUNT_DEF = 8'h80;

  localparam logic [9:0] ST_CNT_RST = 10'h000;
  localparam logic [10:0] PER_RST = 11'h000;
  localparam logic [8:0] OC_CNT_RST = 9'h000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HS, ST_BBM_LS, ST_LS, ST_BBM_HS, ST_DIODE
  } bfs_state_t;

  typedef struct packed {
    logic ramp_cross;
    logic zero_cross;
    logic valley_over;
    logic output_under_threshold;
    logic output_over_threshold;
    logic input_over_threshold;
    logic input_below_off;
    logic input_above_on;
  } bfs_sense_t;

  typedef struct packed {
    logic power_save;
    logic ultrasonic;
    logic [9:0] on_time;
    logic [7:0] oc_count_limit;
  } bfs_cfg_t;

  typedef struct packed {
    logic overcurrent_guard;
    logic output_low_guard;
    logic output_high_guard;
    logic input_high_guard;
    logic input_low_guard;
  } bfs_fault_t;

  localparam bfs_fault_t FAULT_RST = 5'h00;

endpackage

// ---- hdl/bfs_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Ramp crossing fires a fixed on-time pulse that drives the high-side switch
// - After on-time, both switches off for the dead interval, then low side on
// - Low side stays on for minimum off-time and until next ramp crossing
// - In power-save, zero crossing turns the low side off (diode emulation)
// - Ultrasonic mode, together with power-save, keeps the switching rate above 20 kHz
// - Enable high turns the regulator on, low turns it off
// - After blanking in each low-side interval, valley current is checked
// - Valley current over limit skips the high-side pulse, holds low side on
// - Over cfg.oc_count_limit consecutive limited cycles gives overcurrent fault, both off
// - Overcurrent fault retries after the delay until it clears
// - Overcurrent supervision runs as soon as the bias supply is good
// - Output under limit turns both off, retries after the delay
// - Output undervoltage check is masked until soft-start completes
// - Output over limit turns both off, restarts once clear without delay
// - Output overvoltage check runs as soon as the bias supply is good
// - Input over limit turns both off, restarts when input drops back
// - Input below off level turns both off; restart needs input above on level
module bfs_supervisor #(
  parameter int RETRY_CYC = bfs_pkg::RETRY_CYC_DEF,
  parameter int SS_CYC = bfs_pkg::SS_CYC_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pins and analog comparators
  input wire logic enable_pin,
  input wire logic bias_ok,
  input wire bfs_pkg::bfs_sense_t sense,
  // Configuration from management logic
  input wire bfs_pkg::bfs_cfg_t cfg,
  // Switch gates
  output logic high_side_switch,
  output logic low_side_switch,
  // Status
  output bfs_pkg::bfs_fault_t fault_status,
  output logic soft_start_done,
  output logic switching,
  output logic [8:0] oc_count
);

  import bfs_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [9:0] sync_q;
  bfs_sense_t s;
  logic en_s;
  logic bias_s;

  bfs_sync #(.W(10)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({enable_pin, bias_ok, sense}),
    .sync_out(sync_q)
  );
  assign {en_s, bias_s, s} = sync_q;

  // ****************************************************************
  // Shared state
  // ****************************************************************
  bfs_state_t state_ff;
  bfs_state_t nxt_state;
  logic [9:0] st_cnt_ff;
  logic [10:0] per_ff;
  logic [8:0] oc_cnt_ff;
  bfs_fault_t fault_ff;
  logic ss_done_ff;
  logic hs_ff;
  logic ls_ff;
  logic ramp_d_ff;
  logic retry_done;
  logic ss_tmr_done;

  logic ramp_rise;
  logic force_fire;
  logic fire;
  logic minoff_done;
  logic blank_done;
  logic oc_hold;
  logic oc_trip;
  logic uv_trip;
  logic fault_now;
  logic run;
  logic skip_evt;

  assign ramp_rise = s.ramp_cross & ~ramp_d_ff;
  assign force_fire = cfg.power_save & cfg.ultrasonic & (per_ff >= US_FIRE_CYC);
  assign fire = s.ramp_cross | force_fire;
  // Compared without an increment so a saturated count still reads as done
  assign minoff_done = (st_cnt_ff >= MINOFF_CYC - 10'h001);
  assign blank_done = (st_cnt_ff >= BLANK_CYC);
  assign oc_hold = blank_done & s.valley_over;
  assign skip_evt = (state_ff == ST_LS) & minoff_done & oc_hold & ramp_rise;
  assign oc_trip = bias_s & (oc_cnt_ff > {1'b0, cfg.oc_count_limit});
  assign uv_trip = bias_s & ss_done_ff & s.output_under_threshold;
  assign fault_now = (|fault_ff) | oc_trip | uv_trip
                   | (bias_s & (s.output_over_threshold | s.input_over_threshold
                                | s.input_below_off));
  assign run = bias_s & en_s & ~fault_now;

  // ****************************************************************
  // Switching sequence
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_DIODE;
      end
      ST_DIODE: begin
        if (fire) begin
          nxt_state = ST_HS;
        end
      end
      ST_HS: begin
        if (st_cnt_ff + 10'h001 >= cfg.on_time) begin
          nxt_state = ST_BBM_LS;
        end
      end
      ST_BBM_LS: begin
        if (st_cnt_ff + 10'h001 >= DEAD_CYC) begin
          nxt_state = ST_LS;
        end
      end
      ST_LS: begin
        if (minoff_done && !oc_hold) begin
          if (fire) begin
            nxt_state = ST_BBM_HS;
          end else if (cfg.power_save && s.zero_cross) begin
            nxt_state = ST_DIODE;
          end
        end
      end
      ST_BBM_HS: begin
        if (st_cnt_ff + 10'h001 >= DEAD_CYC) begin
          nxt_state = ST_HS;
        end
      end
    endcase
    if (!run) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      st_cnt_ff <= ST_CNT_RST;
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      ramp_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        st_cnt_ff <= ST_CNT_RST;
      end else if (st_cnt_ff != 10'h3FF) begin
        st_cnt_ff <= st_cnt_ff + 10'h001;
      end
      hs_ff <= (nxt_state == ST_HS);
      ls_ff <= (nxt_state == ST_LS);
      ramp_d_ff <= s.ramp_cross;
    end
  end

  // Time since the last high-side start, for the ultrasonic floor
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      per_ff <= PER_RST;
    end else if (state_ff == ST_IDLE || nxt_state == ST_HS && state_ff != ST_HS) begin
      per_ff <= PER_RST;
    end else if (per_ff != 11'h7FF) begin
      per_ff <= per_ff + 11'h001;
    end
  end

  // ****************************************************************
  // Overcurrent counting
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !bias_s || fault_ff.overcurrent_guard) begin
      oc_cnt_ff <= OC_CNT_RST;
    end else if (skip_evt && oc_cnt_ff != 9'h1FF) begin
      oc_cnt_ff <= oc_cnt_ff + 9'h001;
    end else if (nxt_state == ST_HS && state_ff != ST_HS) begin
      oc_cnt_ff <= OC_CNT_RST;
    end
  end

  // ****************************************************************
  // Fault latches and retry
  // ****************************************************************
  bfs_timer #(.W(LONG_W)) u_retry (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(oc_trip | uv_trip),
    .load_val(LONG_W'(RETRY_CYC)),
    .done(retry_done)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !bias_s) begin
      fault_ff <= FAULT_RST;
    end else begin
      if (oc_trip) begin
        fault_ff.overcurrent_guard <= 1'b1;
      end else if (retry_done) begin
        fault_ff.overcurrent_guard <= 1'b0;
      end
      if (uv_trip) begin
        fault_ff.output_low_guard <= 1'b1;
      end else if (retry_done) begin
        fault_ff.output_low_guard <= 1'b0;
      end
      fault_ff.output_high_guard <= s.output_over_threshold;
      fault_ff.input_high_guard <= s.input_over_threshold;
      if (s.input_below_off) begin
        fault_ff.input_low_guard <= 1'b1;
      end else if (s.input_above_on) begin
        fault_ff.input_low_guard <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Soft-start
  // ****************************************************************
  bfs_timer #(.W(LONG_W)) u_ss (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(state_ff == ST_IDLE),
    .load_val(LONG_W'(SS_CYC)),
    .done(ss_tmr_done)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ss_done_ff <= 1'b0;
    end else begin
      ss_done_ff <= (state_ff != ST_IDLE) & ss_tmr_done;
    end
  end

  assign high_side_switch = hs_ff;
  assign low_side_switch = ls_ff;
  assign fault_status = fault_ff;
  assign soft_start_done = ss_done_ff;
  assign switching = (state_ff != ST_IDLE);
  assign oc_count = oc_cnt_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [10:0] hs_len_ff;
  logic [10:0] ls_len_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hs_len_ff <= PER_RST;
      ls_len_ff <= PER_RST;
    end else begin
      hs_len_ff <= hs_ff ? hs_len_ff + 11'h001 : PER_RST;
      ls_len_ff <= ls_ff ? ls_len_ff + 11'h001 : PER_RST;
    end
  end

  sequence s_hs_end;
    $fell(high_side_switch) && $past(run);
  endsequence

  sequence s_ls_end;
    $fell(low_side_switch) && $past(run);
  endsequence

  property p_dead_gap;
    @(posedge ref_clk) disable iff (sys_rst)
      $fell(high_side_switch) |-> !low_side_switch [*2];
  endproperty

  a_no_overlap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(high_side_switch && low_side_switch)) else $error("gates overlap");
  a_on_time_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_hs_end and (cfg.on_time != 10'h000) |-> hs_len_ff == {1'b0, cfg.on_time})
    else $error("on-time pulse length wrong");
  a_dead_gap: assert property (p_dead_gap) else $error("dead interval too short");
  a_min_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_ls_end |-> ls_len_ff >= {1'b0, MINOFF_CYC})
    else $error("low side shorter than minimum");
  a_diode_emul: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run && state_ff == ST_LS && minoff_done && !oc_hold && !fire && cfg.power_save
    && s.zero_cross |=> !low_side_switch) else $error("diode emulation missed");
  a_ultra_period: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg.power_save && cfg.ultrasonic && $stable(cfg) |-> per_ff <= US_MAX_CYC)
    else $error("switching period over ultrasonic bound");
  a_enable_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !en_s |=> !high_side_switch && !low_side_switch)
    else $error("gates on while disabled");
  a_oc_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run && state_ff == ST_LS && oc_hold |=> low_side_switch && !high_side_switch)
    else $error("low side not held during overcurrent");
  a_oc_trip: assert property (@(posedge ref_clk) disable iff (sys_rst)
    oc_trip |=> fault_status.overcurrent_guard ##1 !high_side_switch && !low_side_switch)
    else $error("overcurrent fault not raised");
  a_oc_retry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fault_status.overcurrent_guard && bias_s && !retry_done
    |=> fault_status.overcurrent_guard || !bias_s)
    else $error("overcurrent fault cleared before delay");
  a_uv_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !soft_start_done && !fault_status.output_low_guard |=> !fault_status.output_low_guard)
    else $error("undervoltage checked during soft-start");
  a_ov_trip: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bias_s && s.output_over_threshold |=> !high_side_switch && !low_side_switch)
    else $error("gates on during output overvoltage");
  a_in_low_hyst: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fault_status.input_low_guard && bias_s && !s.input_above_on
    |=> fault_status.input_low_guard)
    else $error("input undervoltage cleared early");

endmodule // bfs_supervisor
`default_nettype wire

// ---- hdl/bfs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-flop synchroniser, one chain per bit
// ****************************************************************
module bfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[i] = sync_ff;
    end
  endgenerate

endmodule // bfs_sync
`default_nettype wire

// ---- hdl/bfs_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Loadable down counter with zero flag
// ****************************************************************
module bfs_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic done
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign done = (cnt_ff == '0);

endmodule // bfs_timer
`default_nettype wire

// ---- test/bfs_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Power stage and comparator model
// ****************************************************************
module bfs_stage_model #(
  parameter int ZC_DLY = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Gates from the controller
  input wire logic high_side_switch,
  input wire logic low_side_switch,
  // Comparator levels wanted by the bench
  input wire bfs_pkg::bfs_sense_t lvl,
  // Comparator outputs
  output bfs_pkg::bfs_sense_t sense
);
  import bfs_pkg::*;

  logic [5:0] ramp_ph_ff;
  logic [7:0] ls_on_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ramp_ph_ff <= 6'h00;
    end else begin
      ramp_ph_ff <= ramp_ph_ff + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !low_side_switch) begin
      ls_on_ff <= 8'h00;
    end else if (ls_on_ff != 8'hFF) begin
      ls_on_ff <= ls_on_ff + 8'h01;
    end
  end

  always_comb begin
    sense = lvl;
    // Ramp is above the error level 4 cycles in every 64
    sense.ramp_cross = lvl.ramp_cross && (ramp_ph_ff[5:2] == 4'hF);
    // Inductor current decays to zero a fixed time into the low-side interval
    sense.zero_cross = lvl.zero_cross && (ls_on_ff >= 8'(ZC_DLY));
    // Valley current is only sensed through the conducting low side
    sense.valley_over = lvl.valley_over && low_side_switch;
  end
endmodule // bfs_stage_model
`default_nettype wire

// ---- test/bfs_supervisor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Supervisor testbench
// ****************************************************************
module bfs_supervisor_tb;
  import bfs_pkg::*;

  localparam int RETRY = 300;
  localparam int SS = 2000;

  logic ref_clk, sys_rst, enable_pin, bias_ok, high_side_switch, low_side_switch;
  logic soft_start_done, switching, watch_hs;
  logic [8:0] oc_count;
  bfs_sense_t lvl, sense;
  bfs_cfg_t cfg;
  bfs_fault_t fault_status;
  int n_mismatch, checks_done, hs_bad, n, n1, k;

  bfs_supervisor #(.RETRY_CYC(RETRY), .SS_CYC(SS)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .enable_pin(enable_pin), .bias_ok(bias_ok),
    .sense(sense), .cfg(cfg), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .fault_status(fault_status),
    .soft_start_done(soft_start_done), .switching(switching), .oc_count(oc_count)
  );

  bfs_stage_model stage_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .lvl(lvl), .sense(sense)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts cycles with the high side on while a pulse must be skipped
  always @(negedge ref_clk) begin
    if (watch_hs === 1'b1 && high_side_switch !== 1'b0) begin
      hs_bad++;
    end
  end

  // ****************************************************************
  // Checking and waiting
  // ****************************************************************
  task automatic end_of_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  // Waits at falling edges until the chosen output shows val
  task automatic wt(input int sel, input logic val, input int lim, output int cnt);
    logic s;
    cnt = 0;
    forever begin
      case (sel)
        0: s = high_side_switch;
        1: s = low_side_switch;
        2: s = |fault_status;
        3: s = soft_start_done;
        default: s = switching;
      endcase
      if (s === val) begin
        return;
      end
      if (cnt >= lim) begin
        n_mismatch++;
        $display("[ERR] t=%0t wait=%0h cycles=%0h", $time, sel, cnt);
        end_of_test();
      end
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    enable_pin = 1'b0;
    bias_ok = 1'b0;
    watch_hs = 1'b0;
    lvl = '0;
    cfg = '{1'b0, 1'b0, 10'h005, 8'h03};
    n_mismatch = 0;
    checks_done = 0;
    hs_bad = 0;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({high_side_switch, low_side_switch, switching, fault_status}, 32'h0);
    enable_pin = 1'b1;
    @(negedge ref_clk);
    bias_ok = 1'b1;
    lvl.ramp_cross = 1'b1;
    // Normal switching cycle
    wt(0, 1'b1, 200, n);
    wt(0, 1'b0, 20, n);
    chk(n, 32'h5);
    wt(1, 1'b1, 20, n);
    chk(n, DEAD_CYC);
    wt(1, 1'b0, 100, n);
    rng(n, MINOFF_CYC, 70);
    wt(0, 1'b1, 20, n);
    chk(n, DEAD_CYC);
    // Diode emulation cuts the low-side interval short
    cfg.power_save = 1'b1;
    lvl.zero_cross = 1'b1;
    wt(1, 1'b1, 100, n);
    wt(1, 1'b0, 100, n);
    rng(n, MINOFF_CYC, 16);
    // Ultrasonic floor with no ramp crossing at all
    cfg.ultrasonic = 1'b1;
    lvl.ramp_cross = 1'b0;
    wt(0, 1'b0, 20, n);
    wt(0, 1'b1, 2100, n);
    wt(0, 1'b0, 20, n1);
    wt(0, 1'b1, 2100, n);
    rng(n + n1, 1, US_MAX_CYC);
    cfg.power_save = 1'b0;
    cfg.ultrasonic = 1'b0;
    lvl.zero_cross = 1'b0;
    lvl.ramp_cross = 1'b1;
    // Enable low stops switching
    enable_pin = 1'b0;
    wt(4, 1'b0, 6, n);
    chk({high_side_switch, low_side_switch}, 32'h0);
    enable_pin = 1'b1;
    // Persistent valley overcurrent, counted fault and timed retry
    wt(0, 1'b1, 200, n);
    lvl.valley_over = 1'b1;
    wt(0, 1'b0, 20, n);
    watch_hs = 1'b1;
    wt(2, 1'b1, 600, n);
    watch_hs = 1'b0;
    rng(n, 150, 600);
    chk(hs_bad, 32'h0);
    chk(fault_status, 32'h10);
    chk(oc_count, 32'h4);
    chk(soft_start_done, 32'h0);
    @(negedge ref_clk);
    chk({high_side_switch, low_side_switch}, 32'h0);
    chk(oc_count, 32'h0);
    lvl.valley_over = 1'b0;
    wt(2, 1'b0, RETRY + 100, n);
    rng(n, RETRY - 2, RETRY + 10);
    chk(soft_start_done, 32'h0);
    wt(0, 1'b1, 400, n);
    chk(high_side_switch, 32'h1);
    // Output undervoltage is ignored until soft-start ends
    lvl.output_under_threshold = 1'b1;
    wt(3, 1'b1, SS + 100, n);
    chk(fault_status, 32'h0);
    wt(2, 1'b1, 5, n);
    chk(fault_status, 32'h08);
    @(negedge ref_clk);
    chk({high_side_switch, low_side_switch}, 32'h0);
    lvl.output_under_threshold = 1'b0;
    wt(2, 1'b0, RETRY + 100, n);
    rng(n, RETRY - 2, RETRY + 10);
    // Output over, input over and input under, during soft-start
    for (k = 0; k < 3; k++) begin
      lvl[3 - k] = 1'b1;
      wt(2, 1'b1, 5, n);
      chk(fault_status, 32'(1 << (2 - k)));
      chk(soft_start_done, 32'h0);
      @(negedge ref_clk);
      chk({high_side_switch, low_side_switch}, 32'h0);
      lvl[3 - k] = 1'b0;
      if (k == 2) begin
        repeat (20) @(negedge ref_clk);
        chk(fault_status, 32'h01);
        lvl.input_above_on = 1'b1;
      end
      wt(2, 1'b0, 6, n);
      rng(n, 1, 6);
    end
    end_of_test();
  end
endmodule // bfs_supervisor_tb
`default_nettype wire
